// ### common/wwd_defines.svh
// timing and encoding constants of the window watchdog and reset generator
`ifndef WWD_DEFINES_SVH
`define WWD_DEFINES_SVH

// oscillator clocks per watchdog cycle
`define WWD_CYCLE_DIV 100
// watchdog cycle counts
`define WWD_POR_DELAY_CYC 64
`define WWD_CLOSED_CYC 32
`define WWD_OPEN_CYC 32
`define WWD_FAULT_DELAY_CYC 64
`define WWD_FAULT_RST_CYC 64
// oscillator clock period in picoseconds
`define WWD_CLK_PERIOD_PS 4000
// reset reaction time in nanoseconds
`define WWD_RR_TIME_NS 10000
// least time, so rounded up to whole clocks
`define WWD_RR_CLKS ((`WWD_RR_TIME_NS * 1000 + `WWD_CLK_PERIOD_PS - 1) / `WWD_CLK_PERIOD_PS)
// sample history, oldest sample in the msb: high, high, low, low
`define WWD_TRIG_PATTERN 4'hc
// counter widths
`define WWD_CYC_CNT_W 7
`define WWD_RR_CNT_W 16
`define WWD_DIV_CNT_W 8

`endif

// ### common/wwd_pkg.sv
// types shared by the window watchdog and reset generator
`include "wwd_defines.svh"

package wwd_pkg;

    typedef enum logic [2:0] {
        WWD_ST_POR,
        WWD_ST_CLOSED,
        WWD_ST_OPEN,
        WWD_ST_FAULT_WAIT,
        WWD_ST_FAULT_RST
    } wwd_state_t;

    typedef struct packed {
        wwd_state_t state;
        logic [`WWD_CYC_CNT_W-1:0] cyc_cnt;
        logic [3:0] hist;
        logic [`WWD_RR_CNT_W-1:0] rr_cnt;
        logic reset_out_n;
        logic system_enable_out;
    } wwd_core_t;

    typedef struct packed {
        logic [`WWD_DIV_CNT_W-1:0] cnt;
        logic tick;
    } wwd_div_t;

endpackage

// ### hdl/wwd_cycle_div.sv
// divider that turns the oscillator clock into the watchdog cycle enable
`timescale 1ns/100ps
`include "wwd_defines.svh"

module wwd_cycle_div #(
    parameter int DIV = `WWD_CYCLE_DIV
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    output logic tick_o
);

    wwd_pkg::wwd_div_t div_ff;
    wwd_pkg::wwd_div_t nxt_div;

    if (DIV < 2 || DIV > (1 << `WWD_DIV_CNT_W)) begin : g_bad_div
        $error("wwd_cycle_div: DIV out of range");
    end

    always_comb begin
        nxt_div = div_ff;
        nxt_div.tick = 1'b0;
        if (div_ff.cnt == `WWD_DIV_CNT_W'(DIV - 1)) begin
            nxt_div.cnt = '0;
            nxt_div.tick = 1'b1;
        end else begin
            nxt_div.cnt = div_ff.cnt + `WWD_DIV_CNT_W'(1);
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            div_ff <= '0;
        end else begin
            div_ff <= nxt_div;
        end
    end

    assign tick_o = div_ff.tick;

endmodule

// ### hdl/wwd_top.sv
// window watchdog with power-on/power-down reset and system enable output
//
// Overview of operation
// - watchdog cycle is one hundred oscillator clocks
// - reset held low 64 cycles after power-on
// - reset release starts 32-cycle closed window
// - trigger inside closed window is a pretrigger
// - open window ends at trigger, at most 32
// - trigger is two high then two low samples
// - good trigger or reset release restarts closed window
// - fault: reset 64 after window start, 64 long
// - fourth sample in open window still counts good
// - enable goes high on first good trigger
// - enable drops at once on any fault
// - reset only after dip beyond reaction time
// - power-up delay after supply returns above threshold
`timescale 1ns/100ps
`include "wwd_defines.svh"

module wwd_top #(
    parameter int CYCLE_DIV = `WWD_CYCLE_DIV,
    parameter int RR_CLKS = `WWD_RR_CLKS
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    // high while the supply sits below the reset threshold
    input wire logic supply_low_i,
    input wire logic trigger_in_i,
    output logic reset_out_n_o,
    output logic system_enable_out_o
);

    // ------------------------------------------------------------
    // parameter checks and constants
    // ------------------------------------------------------------
    localparam int CW = `WWD_CYC_CNT_W;
    localparam int RW = `WWD_RR_CNT_W;
    localparam logic [CW-1:0] POR_LAST = CW'(`WWD_POR_DELAY_CYC - 1);
    localparam logic [CW-1:0] CLOSED_LAST = CW'(`WWD_CLOSED_CYC - 1);
    localparam logic [CW-1:0] OPEN_LAST = CW'(`WWD_CLOSED_CYC + `WWD_OPEN_CYC - 1);
    localparam logic [CW-1:0] FAULT_LAST = CW'(`WWD_FAULT_DELAY_CYC - 1);
    localparam logic [CW-1:0] FRST_LAST = CW'(`WWD_FAULT_RST_CYC - 1);
    localparam logic [RW-1:0] RR_LIMIT = RW'(RR_CLKS);

    // refused at elaboration: the counters could not reach these end points
    if (RR_CLKS < 1 || RR_CLKS >= (1 << RW)) begin : g_bad_rr
        $error("wwd_top: RR_CLKS out of range");
    end
    if (`WWD_CLOSED_CYC + `WWD_OPEN_CYC > (1 << CW)) begin : g_bad_cw
        $error("wwd_top: window counter too narrow");
    end
    if (`WWD_POR_DELAY_CYC > (1 << CW) || `WWD_FAULT_RST_CYC > (1 << CW)) begin : g_bad_delay
        $error("wwd_top: delay counter too narrow");
    end

    // ------------------------------------------------------------
    // watchdog cycle enable
    // ------------------------------------------------------------
    // the tick is registered, so each window step lands one clock after
    // the divider wraps; one clock of latency traded for a clean enable
    logic cyc_tick;

    wwd_cycle_div #(
        .DIV(CYCLE_DIV)
    ) u_div (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .tick_o(cyc_tick)
    );

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    wwd_pkg::wwd_core_t core_ff;
    wwd_pkg::wwd_core_t nxt_core;

    logic [3:0] new_hist;
    logic trig_valid;
    logic power_down;

    always_comb begin
        nxt_core = core_ff;
        new_hist = {core_ff.hist[2:0], trigger_in_i};
        // a trigger is decided on the tick of its fourth sample
        trig_valid = cyc_tick && (new_hist == `WWD_TRIG_PATTERN);

        // --------------------------------------------------------
        // supply glitch filter, counted on the oscillator clock
        // --------------------------------------------------------
        power_down = 1'b0;
        if (supply_low_i) begin
            if (core_ff.rr_cnt == RR_LIMIT) begin
                // low for longer than the reaction time
                power_down = 1'b1;
            end else begin
                nxt_core.rr_cnt = core_ff.rr_cnt + RW'(1);
            end
        end else begin
            // short dips are forgotten entirely
            nxt_core.rr_cnt = '0;
        end

        // history is never cleared by window changes, so a
        // trigger may straddle the closed/open boundary
        if (cyc_tick) begin
            nxt_core.hist = new_hist;
        end

        // --------------------------------------------------------
        // window sequencer
        // --------------------------------------------------------
        case (core_ff.state)
            wwd_pkg::WWD_ST_POR: begin
                nxt_core.reset_out_n = 1'b0;
                nxt_core.system_enable_out = 1'b0;
                if (supply_low_i) begin
                    // delay counts only once the supply is back
                    nxt_core.cyc_cnt = '0;
                end else if (cyc_tick) begin
                    if (core_ff.cyc_cnt == POR_LAST) begin
                        nxt_core.state = wwd_pkg::WWD_ST_CLOSED;
                        nxt_core.cyc_cnt = '0;
                        nxt_core.reset_out_n = 1'b1;
                    end else begin
                        nxt_core.cyc_cnt = core_ff.cyc_cnt + CW'(1);
                    end
                end
            end
            wwd_pkg::WWD_ST_CLOSED: begin
                if (trig_valid) begin
                    // pretrigger: keep counting from the window start
                    nxt_core.state = wwd_pkg::WWD_ST_FAULT_WAIT;
                    nxt_core.system_enable_out = 1'b0;
                    nxt_core.cyc_cnt = core_ff.cyc_cnt + CW'(1);
                end else if (cyc_tick) begin
                    if (core_ff.cyc_cnt == CLOSED_LAST) begin
                        nxt_core.state = wwd_pkg::WWD_ST_OPEN;
                    end
                    nxt_core.cyc_cnt = core_ff.cyc_cnt + CW'(1);
                end
            end
            wwd_pkg::WWD_ST_OPEN: begin
                if (trig_valid) begin
                    // includes the case of only the fourth sample here
                    nxt_core.state = wwd_pkg::WWD_ST_CLOSED;
                    nxt_core.cyc_cnt = '0;
                    nxt_core.system_enable_out = 1'b1;
                end else if (cyc_tick) begin
                    if (core_ff.cyc_cnt == OPEN_LAST) begin
                        // missing trigger: 64 cycles since start elapsed
                        nxt_core.state = wwd_pkg::WWD_ST_FAULT_RST;
                        nxt_core.cyc_cnt = '0;
                        nxt_core.reset_out_n = 1'b0;
                        nxt_core.system_enable_out = 1'b0;
                    end else begin
                        nxt_core.cyc_cnt = core_ff.cyc_cnt + CW'(1);
                    end
                end
            end
            wwd_pkg::WWD_ST_FAULT_WAIT: begin
                // further triggers change nothing until the reset
                if (cyc_tick) begin
                    if (core_ff.cyc_cnt == FAULT_LAST) begin
                        nxt_core.state = wwd_pkg::WWD_ST_FAULT_RST;
                        nxt_core.cyc_cnt = '0;
                        nxt_core.reset_out_n = 1'b0;
                    end else begin
                        nxt_core.cyc_cnt = core_ff.cyc_cnt + CW'(1);
                    end
                end
            end
            wwd_pkg::WWD_ST_FAULT_RST: begin
                nxt_core.reset_out_n = 1'b0;
                nxt_core.system_enable_out = 1'b0;
                if (cyc_tick) begin
                    if (core_ff.cyc_cnt == FRST_LAST) begin
                        nxt_core.state = wwd_pkg::WWD_ST_CLOSED;
                        nxt_core.cyc_cnt = '0;
                        nxt_core.reset_out_n = 1'b1;
                    end else begin
                        nxt_core.cyc_cnt = core_ff.cyc_cnt + CW'(1);
                    end
                end
            end
            default: begin
                nxt_core.state = wwd_pkg::WWD_ST_POR;
                nxt_core.cyc_cnt = '0;
                nxt_core.reset_out_n = 1'b0;
                nxt_core.system_enable_out = 1'b0;
            end
        endcase

        // power down overrides every window state
        if (power_down) begin
            nxt_core.state = wwd_pkg::WWD_ST_POR;
            nxt_core.cyc_cnt = '0;
            nxt_core.reset_out_n = 1'b0;
            nxt_core.system_enable_out = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            core_ff.state <= wwd_pkg::WWD_ST_POR;
            core_ff.cyc_cnt <= '0;
            core_ff.hist <= '0;
            core_ff.rr_cnt <= '0;
            core_ff.reset_out_n <= 1'b0;
            core_ff.system_enable_out <= 1'b0;
        end else begin
            core_ff <= nxt_core;
        end
    end

    assign reset_out_n_o = core_ff.reset_out_n;
    assign system_enable_out_o = core_ff.system_enable_out;

endmodule

// ### sim/wwd_top_props.sv
// concurrent checks on the window watchdog top ports
`timescale 1ns/100ps
module wwd_top_props #(
    parameter int CYCLE_DIV = 100,
    parameter int RR_CLKS = 2500
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic supply_low_i,
    input wire logic trigger_in_i,
    input wire logic reset_out_n_o,
    input wire logic system_enable_out_o
);
    // ---------------------------------------------
    // tick phase and level-duration counters
    // ---------------------------------------------
    // outputs move on the edge after a tick, one clock past each divider wrap
    localparam int TICK_PH = 1;
    int ph_ff;
    int low_ff;
    int high_ff;
    // consecutive clocks with the supply below the threshold
    int dip_ff;
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ph_ff <= 0;
            low_ff <= 0;
            high_ff <= 0;
            dip_ff <= 0;
        end else begin
            ph_ff <= (ph_ff == CYCLE_DIV - 1) ? 0 : ph_ff + 1;
            low_ff <= reset_out_n_o ? 0 : low_ff + 1;
            high_ff <= reset_out_n_o ? high_ff + 1 : 0;
            dip_ff <= supply_low_i ? dip_ff + 1 : 0;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    // dip lengths assume RR_CLKS of 4 as the bench sets it
    sequence s_short_dip;
        (reset_out_n_o && !supply_low_i) ##1 supply_low_i [*4] ##1 !supply_low_i;
    endsequence
    sequence s_long_dip;
        supply_low_i [*5];
    endsequence
    chk_enable_needs_release: assert property (system_enable_out_o |-> reset_out_n_o)
        else $error("enable high while reset low");
    chk_enable_rise_tick: assert property ($rose(system_enable_out_o) |->
        ph_ff == TICK_PH && $past(reset_out_n_o))
        else $error("enable rose off a tick");
    chk_release_on_tick: assert property ($rose(reset_out_n_o) |-> ph_ff == TICK_PH)
        else $error("reset released off a tick");
    chk_reset_hold: assert property ($rose(reset_out_n_o) |-> low_ff >= 64 * CYCLE_DIV - 1)
        else $error("reset low too short");
    chk_fault_spacing: assert property ($fell(reset_out_n_o) && !$past(supply_low_i) |->
        high_ff >= 64 * CYCLE_DIV - 1 && ph_ff == TICK_PH)
        else $error("fault reset too early");
    chk_short_dip: assert property (s_short_dip |-> reset_out_n_o)
        else $error("short dip caused reset");
    chk_long_dip: assert property (s_long_dip |-> ##[1:2]
        (!reset_out_n_o && !system_enable_out_o))
        else $error("long dip gave no reset");
    chk_supply_hold: assert property (supply_low_i && dip_ff >= RR_CLKS |=> !reset_out_n_o)
        else $error("reset released while supply low");
endmodule
bind wwd_top wwd_top_props #(.CYCLE_DIV(CYCLE_DIV), .RR_CLKS(RR_CLKS)) u_props (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .supply_low_i(supply_low_i),
    .trigger_in_i(trigger_in_i), .reset_out_n_o(reset_out_n_o),
    .system_enable_out_o(system_enable_out_o));

// ### sim/wwd_mcu_model.sv
// controller model that pulses the watchdog trigger
`timescale 1ns/100ps
module wwd_mcu_model #(
    parameter int DIV = 4
) (
    input wire logic clk_i,
    input wire logic reset_out_n_i,
    input wire logic [7:0] gap_i,
    output logic trigger_in_o
);
    // ---------------------------------------------
    // gap counts ticks from window start to the rising level
    // ---------------------------------------------
    int cnt_ff = 0;
    int gap_ff = 30;
    logic rel_ff = 1'b0;
    initial trigger_in_o = 1'b0;
    always @(posedge clk_i) begin
        rel_ff <= reset_out_n_i;
        if (!reset_out_n_i) begin
            cnt_ff <= 0;
        end else if (!rel_ff || cnt_ff == DIV * gap_ff + 3 * DIV - 1) begin
            cnt_ff <= rel_ff ? 0 : 1;
            gap_ff <= int'(gap_i);
        end else begin
            cnt_ff <= cnt_ff + 1;
        end
    end
    // each level is held across two samples
    always @(negedge clk_i) begin
        if (cnt_ff == DIV * gap_ff - 2) begin
            trigger_in_o <= 1'b1;
        end else if (cnt_ff == DIV * gap_ff + 2 * DIV - 2) begin
            trigger_in_o <= 1'b0;
        end
    end
endmodule

// ### sim/wwd_top_tb_top.sv
// self-checking bench for the window watchdog top
`timescale 1ns/100ps
module wwd_top_tb_top;
    localparam int DIV = 4;
    // the registered cycle tick puts the release one clock after 64 cycles
    localparam int TICK_LAG = 1;
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic supply_low_i = 1'b0;
    logic trigger_in_i;
    logic reset_out_n_o;
    logic system_enable_out_o;
    logic [7:0] gap = 8'h1e;
    int mismatches = 0;
    int comparisons = 0;
    int n;
    always #2 clk_i = ~clk_i;
    wwd_top #(.CYCLE_DIV(DIV), .RR_CLKS(4)) uut (.clk_i(clk_i), .reset_n_i(reset_n_i),
        .supply_low_i(supply_low_i), .trigger_in_i(trigger_in_i),
        .reset_out_n_o(reset_out_n_o), .system_enable_out_o(system_enable_out_o));
    wwd_mcu_model #(.DIV(DIV)) u_mcu (.clk_i(clk_i), .reset_out_n_i(reset_out_n_o),
        .gap_i(gap), .trigger_in_o(trigger_in_i));
    // ---------------------------------------------
    // checking helpers
    // ---------------------------------------------
    task automatic give_verdict();
        if (mismatches == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic cmp_bit(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            $display("unexpected %0t level %b not %b", $time, got, exp);
            mismatches++;
        end
    endtask
    task automatic cmp_int(input int got, input int exp);
        comparisons++;
        if (got != exp) begin
            $display("unexpected %0t count %0d not %0d", $time, got, exp);
            mismatches++;
        end
    endtask
    // counts falling edges until the chosen output shows val
    task automatic wait_for(input bit sel, input logic val, output int cnt);
        cnt = 0;
        while ((sel ? system_enable_out_o : reset_out_n_o) !== val) begin
            @(negedge clk_i);
            cnt++;
            if (cnt > 3000) begin
                $display("unexpected %0t wait timed out", $time);
                mismatches++;
                give_verdict();
            end
        end
    endtask
    task automatic t_por();
        wait_for(0, 1'b1, n);
        cmp_int(n, 64 * DIV + TICK_LAG);
        cmp_bit(system_enable_out_o, 1'b0);
        wait_for(1, 1'b1, n);
        cmp_int(n, 33 * DIV);
    endtask
    task automatic t_valid();
        gap = 8'h28;
        repeat (800) @(negedge clk_i);
        cmp_bit(reset_out_n_o, 1'b1);
        cmp_bit(system_enable_out_o, 1'b1);
    endtask
    task automatic t_pretrig();
        gap = 8'h1d;
        wait_for(1, 1'b0, n);
        wait_for(0, 1'b0, n);
        cmp_int(n, 32 * DIV);
        wait_for(0, 1'b1, n);
        cmp_int(n, 64 * DIV);
    endtask
    task automatic t_missing();
        // one good window first, so that the enable has something to drop
        gap = 8'h28;
        wait_for(1, 1'b1, n);
        cmp_int(n, 43 * DIV);
        gap = 8'h64;
        // the model runs one more window of the old gap before the long one
        wait_for(0, 1'b0, n);
        cmp_int(n, (43 + 64) * DIV);
        cmp_bit(system_enable_out_o, 1'b0);
    endtask
    task automatic t_dip();
        gap = 8'h28;
        wait_for(0, 1'b1, n);
        cmp_int(n, 64 * DIV);
        wait_for(1, 1'b1, n);
        cmp_int(n, 43 * DIV);
        supply_low_i = 1'b1;
        repeat (4) @(negedge clk_i);
        supply_low_i = 1'b0;
        repeat (2) @(negedge clk_i);
        cmp_bit(reset_out_n_o, 1'b1);
        supply_low_i = 1'b1;
        repeat (8) @(negedge clk_i);
        cmp_bit(reset_out_n_o, 1'b0);
        cmp_bit(system_enable_out_o, 1'b0);
        supply_low_i = 1'b0;
        wait_for(0, 1'b1, n);
        cmp_bit(n > 63 * DIV && n <= 64 * DIV, 1'b1);
    endtask
    initial begin
        repeat (10) @(negedge clk_i);
        reset_n_i = 1'b1;
        t_por();
        t_valid();
        t_pretrig();
        t_missing();
        t_dip();
        give_verdict();
    end
endmodule
